// file: rtl/lnac_top.sv
// Purpose: Node identity, last acknowledge and control bank of a serial-bus link
// Assumes: Host pins are asynchronous; link-side inputs run on ref_clk_i
// Notes: One register access per chip-select assertion
`timescale 1ns/1ps
`default_nettype none
module lnac_top
  import lnac_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Host pins
  input wire logic host_cs_n_i,
  input wire logic host_wr_i,
  input wire logic [7:0] register_address_lines_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  output logic host_done_o,
  // Diagnostic override from the diagnostic register
  input wire logic diag_register_write_override_i,
  // Acknowledge events from the transmitter
  input wire logic at_ack_valid_i,
  input wire logic [3:0] at_ack_code_i,
  input wire logic at_ack_timeout_i,
  // Incoming packet header
  input wire logic rx_hdr_valid_i,
  input wire logic [15:0] rx_dest_id_i,
  input wire logic rx_region_low_i,
  input wire logic rx_region_high_i,
  output logic rx_accept_valid_o,
  output logic rx_accept_o,
  // Busy acknowledge selection
  input wire logic rx_ack_req_i,
  input wire logic rx_busy_needed_i,
  input wire logic [1:0] rx_retry_code_i,
  output logic busy_ack_valid_o,
  output logic [3:0] busy_ack_code_o,
  // Self-id collection
  input wire logic selfid_valid_i,
  input wire logic [31:0] selfid_q0_i,
  input wire logic [31:0] selfid_q1_i,
  output logic selfid_store_o,
  output logic [3:0] selfid_status_o,
  // Transmitter gating and identity
  input wire logic tx_arb_request_i,
  output logic tx_arb_request_o,
  output logic [15:0] source_id_o,
  output logic identity_valid_o
);
  // ==========================================================
  // Host pin synchronisers
  logic [41:0] host_raw;
  logic [41:0] host_s;
  logic cs_s;
  logic wr_s;
  logic [7:0] addr_s;
  logic [31:0] wdata_s;

  assign host_raw = {host_cs_n_i, host_wr_i, register_address_lines_i, host_wdata_i};

  lnac_sync #(.W(42), .RST_VAL({1'b1, 41'd0})) u_host_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(host_raw),
    .q_o(host_s)
  );

  assign cs_s = !host_s[41];
  assign wr_s = host_s[40];
  assign addr_s = host_s[39:32];
  assign wdata_s = host_s[31:0];

  // ==========================================================
  // Host access decode
  logic cs_prev_r;
  logic cs_prev_nxt;
  logic access;
  logic wr_node;
  logic wr_ctrl;
  logic rd_acc;

  always_comb begin
    cs_prev_nxt = cs_s;
    // One access per assertion; addr and data are stable by then
    access = cs_s && !cs_prev_r;
    wr_node = access && wr_s && (addr_s == LNAC_OFF_NODE);
    wr_ctrl = access && wr_s && (addr_s == LNAC_OFF_CTRL);
    rd_acc = access && !wr_s;
  end

  // ==========================================================
  // Registers
  logic [31:0] node_r;
  logic [31:0] node_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic done_r;
  logic done_nxt;
  logic [31:0] node_wmask;

  always_comb begin
    node_nxt = node_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    node_wmask = LNAC_NODE_ID_MASK;
    if (diag_register_write_override_i) begin
      node_wmask = LNAC_NODE_ID_MASK | LNAC_NODE_ACK_MASK;
    end
    if (wr_node) begin
      // Reserved bits are outside the mask and keep their reset ones
      node_nxt = (node_r & ~node_wmask) | (wdata_s & node_wmask);
    end
    // Hardware capture wins over a host write in the same cycle
    if (at_ack_valid_i) begin
      node_nxt[LNAC_ACK_MSB:LNAC_ACK_LSB] = at_ack_code_i;
    end else if (at_ack_timeout_i) begin
      node_nxt[LNAC_ACK_MSB:LNAC_ACK_LSB] = LNAC_ACK_TIMEOUT;
    end
    if (wr_ctrl) begin
      ctrl_nxt = wdata_s;
    end
    if (rd_acc) begin
      case (addr_s)
        LNAC_OFF_NODE: rdata_nxt = node_r;
        LNAC_OFF_CTRL: rdata_nxt = ctrl_r;
        default: rdata_nxt = LNAC_RD_NONE;
      endcase
    end
    done_nxt = cs_s && (done_r || access);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      node_r <= LNAC_NODE_RST;
      ctrl_r <= LNAC_CTRL_RST;
      rdata_r <= LNAC_RD_NONE;
      done_r <= 1'b0;
      cs_prev_r <= 1'b0;
    end else begin
      node_r <= node_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      cs_prev_r <= cs_prev_nxt;
    end
  end

  // ==========================================================
  // Link-side logic
  logic filt_accept;
  logic [2:0] bsy_mode;
  logic send_busy;
  logic [3:0] busy_code;
  logic selfid_ok;

  lnac_rx_filter u_rx_filter (
    .dest_id_i(rx_dest_id_i),
    .bus_identity_i(node_r[LNAC_BUS_MSB:LNAC_BUS_LSB]),
    .node_identity_i(node_r[LNAC_NODE_MSB:LNAC_NODE_LSB]),
    .identity_valid_i(ctrl_r[LNAC_CTL_IDENTITY_VALID]),
    .block_low_i(ctrl_r[LNAC_CTL_BLK_LO]),
    .block_high_i(ctrl_r[LNAC_CTL_BLK_HI]),
    .region_low_i(rx_region_low_i),
    .region_high_i(rx_region_high_i),
    .accept_o(filt_accept)
  );

  logic acc_v_r, acc_v_nxt, acc_r, acc_nxt;
  logic bv_r, bv_nxt;
  logic [3:0] bc_r, bc_nxt;
  logic ss_r, ss_nxt;
  logic [3:0] st_r, st_nxt;
  logic arb_r, arb_nxt;

  always_comb begin
    bsy_mode = ctrl_r[LNAC_CTL_BSY_MSB:LNAC_CTL_BSY_LSB];
    send_busy = rx_busy_needed_i || bsy_mode[LNAC_BSY_ALL_BIT];
    case (bsy_mode[1:0])
      LNAC_BSY_A: busy_code = LNAC_ACK_BUSY_A;
      LNAC_BSY_B: busy_code = LNAC_ACK_BUSY_B;
      // Normal and reserved codes fall back to the plain protocol
      default: busy_code = LNAC_ACK_BUSY_X;
    endcase
    if (rx_retry_code_i == LNAC_RETRY_X) begin
      busy_code = LNAC_ACK_BUSY_X;
    end
    acc_v_nxt = rx_hdr_valid_i;
    acc_nxt = rx_hdr_valid_i ? filt_accept : acc_r;
    bv_nxt = rx_ack_req_i && send_busy;
    bc_nxt = (rx_ack_req_i && send_busy) ? busy_code : bc_r;
    selfid_ok = (selfid_q1_i == ~selfid_q0_i);
    ss_nxt = selfid_valid_i && ctrl_r[LNAC_CTL_SELFID];
    st_nxt = st_r;
    if (ss_nxt) begin
      st_nxt = selfid_ok ? LNAC_SELFID_GOOD : LNAC_SELFID_BAD;
    end
    arb_nxt = tx_arb_request_i && ctrl_r[LNAC_CTL_TRANSMITTER_ENABLE];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_v_r <= 1'b0;
      acc_r <= 1'b0;
      bv_r <= 1'b0;
      bc_r <= LNAC_ACK_BUSY_X;
      ss_r <= 1'b0;
      st_r <= LNAC_SELFID_GOOD;
      arb_r <= 1'b0;
    end else begin
      acc_v_r <= acc_v_nxt;
      acc_r <= acc_nxt;
      bv_r <= bv_nxt;
      bc_r <= bc_nxt;
      ss_r <= ss_nxt;
      st_r <= st_nxt;
      arb_r <= arb_nxt;
    end
  end

  assign host_rdata_o = rdata_r;
  assign host_done_o = done_r;
  assign rx_accept_valid_o = acc_v_r;
  assign rx_accept_o = acc_r;
  assign busy_ack_valid_o = bv_r;
  assign busy_ack_code_o = bc_r;
  assign selfid_store_o = ss_r;
  assign selfid_status_o = st_r;
  assign tx_arb_request_o = arb_r;
  assign source_id_o = {node_r[LNAC_BUS_MSB:LNAC_BUS_LSB], node_r[LNAC_NODE_MSB:LNAC_NODE_LSB]};
  assign identity_valid_o = ctrl_r[LNAC_CTL_IDENTITY_VALID];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_node_write;
    wr_node && !at_ack_valid_i && !at_ack_timeout_i;
  endsequence

  sequence s_ctrl_read;
    rd_acc && addr_s == LNAC_OFF_CTRL;
  endsequence

  sequence s_busy_plain;
    rx_ack_req_i && send_busy && rx_retry_code_i != LNAC_RETRY_X;
  endsequence

  a_reserved_keep: assert property ($stable(node_r[23:16]) && $stable(node_r[31:28]))
    else $error("reserved node bits changed");
  a_ack_capture: assert property (at_ack_valid_i |=> node_r[27:24] == $past(at_ack_code_i))
    else $error("ack code not captured");
  a_ack_timeout: assert property (at_ack_timeout_i && !at_ack_valid_i |=> node_r[27:24] == 4'h0)
    else $error("ack timeout did not clear field");
  a_ack_readonly: assert property (
    s_node_write and !diag_register_write_override_i
    |=> $stable(node_r[27:24]) && node_r[15:0] == $past(wdata_s[15:0]))
    else $error("ack field written without override");
  a_ctrl_write: assert property (wr_ctrl |=> ctrl_r == $past(wdata_s))
    else $error("control write lost");
  a_ctrl_read: assert property (s_ctrl_read |=> host_rdata_o == $past(ctrl_r))
    else $error("control read data wrong");
  a_tx_gate: assert property (!ctrl_r[5] |=> !tx_arb_request_o)
    else $error("arbitration while transmitter disabled");
  a_selfid_code: assert property (
    selfid_valid_i && ctrl_r[1] |=> selfid_store_o
    && selfid_status_o == ($past(selfid_ok) ? 4'h1 : 4'hd))
    else $error("self-id status wrong");
  a_selfid_off: assert property (
    selfid_valid_i && !ctrl_r[LNAC_CTL_SELFID] |=> !selfid_store_o && $stable(selfid_status_o))
    else $error("self-id stored while disabled");
  a_busy_all: assert property (rx_ack_req_i && ctrl_r[4] |=> busy_ack_valid_o)
    else $error("busy-all mode did not answer busy");
  a_busy_x: assert property (
    rx_ack_req_i && send_busy && rx_retry_code_i == 2'b01 |=> busy_ack_code_o == 4'h4)
    else $error("retry_X not answered with busy_X");
  a_busy_sel_a: assert property (
    s_busy_plain and ctrl_r[3:2] == 2'b01 |=> busy_ack_code_o == LNAC_ACK_BUSY_A)
    else $error("busyA not selected");
  a_busy_sel_b: assert property (
    s_busy_plain and ctrl_r[3:2] == 2'b10 |=> busy_ack_code_o == LNAC_ACK_BUSY_B)
    else $error("busyB not selected");
  a_local_bus: assert property (
    rx_hdr_valid_i && rx_dest_id_i[15:6] == 10'h3ff
    && ctrl_r[0] && rx_dest_id_i[5:0] == node_r[15:10] |=> rx_accept_o)
    else $error("local bus packet rejected");
  a_identity_valid_clear: assert property (
    rx_hdr_valid_i && !ctrl_r[0] && rx_dest_id_i[5:0] != 6'h3f
    |=> rx_accept_valid_o && !rx_accept_o)
    else $error("non-broadcast accepted without identity valid");
  a_bcast_block: assert property (
    rx_hdr_valid_i && rx_dest_id_i[5:0] == LNAC_NODE_BCAST && rx_dest_id_i[5:0] != node_r[15:10]
    && ctrl_r[LNAC_CTL_BLK_LO] && rx_region_low_i |=> rx_accept_valid_o && !rx_accept_o)
    else $error("blocked broadcast accepted");
endmodule : lnac_top
`default_nettype wire

// file: rtl/lnac_pkg.sv
// Purpose: Shared constants for the link node address and control bank
// Assumes: 8-bit byte address bus, 32-bit register data
// Notes: Acknowledge code values are fixed localparams and cannot be overridden
package lnac_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] LNAC_OFF_NODE = 8'h04;
  localparam logic [7:0] LNAC_OFF_CTRL = 8'h08;
  localparam logic [31:0] LNAC_NODE_RST = 32'hffff_0000;
  localparam logic [31:0] LNAC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LNAC_RD_NONE = 32'h0000_0000;

  // ==========================================================
  // Node identity register fields
  localparam int LNAC_BUS_LSB = 0;
  localparam int LNAC_BUS_MSB = 9;
  localparam int LNAC_NODE_LSB = 10;
  localparam int LNAC_NODE_MSB = 15;
  localparam int LNAC_ACK_LSB = 24;
  localparam int LNAC_ACK_MSB = 27;
  localparam logic [31:0] LNAC_NODE_ID_MASK = 32'h0000_ffff;
  localparam logic [31:0] LNAC_NODE_ACK_MASK = 32'h0f00_0000;
  localparam logic [9:0] LNAC_BUS_LOCAL = 10'h3ff;
  localparam logic [5:0] LNAC_NODE_BCAST = 6'h3f;
  localparam logic [3:0] LNAC_ACK_TIMEOUT = 4'h0;

  // ==========================================================
  // Control register fields
  localparam int LNAC_CTL_IDENTITY_VALID = 0;
  localparam int LNAC_CTL_SELFID = 1;
  localparam int LNAC_CTL_BSY_LSB = 2;
  localparam int LNAC_CTL_BSY_MSB = 4;
  localparam int LNAC_CTL_TRANSMITTER_ENABLE = 5;
  localparam int LNAC_CTL_BLK_LO = 12;
  localparam int LNAC_CTL_BLK_HI = 15;

  // ==========================================================
  // Busy selection and acknowledge codes
  localparam logic [1:0] LNAC_BSY_NORMAL = 2'b00;
  localparam logic [1:0] LNAC_BSY_A = 2'b01;
  localparam logic [1:0] LNAC_BSY_B = 2'b10;
  localparam int LNAC_BSY_ALL_BIT = 2;
  localparam logic [1:0] LNAC_RETRY_X = 2'b01;
  localparam logic [3:0] LNAC_ACK_BUSY_X = 4'h4;
  localparam logic [3:0] LNAC_ACK_BUSY_A = 4'h5;
  localparam logic [3:0] LNAC_ACK_BUSY_B = 4'h6;
  localparam logic [3:0] LNAC_SELFID_GOOD = 4'h1;
  localparam logic [3:0] LNAC_SELFID_BAD = 4'hd;
endpackage : lnac_pkg

// file: rtl/lnac_sync.sv
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Group is held stable by the sender while it is sampled
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lnac_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule : lnac_sync
`default_nettype wire

// file: rtl/lnac_rx_filter.sv
// Purpose: Destination address match for incoming packets
// Assumes: Inputs are stable in the cycle they are evaluated
// Notes: Purely combinational; caller registers the verdict
`timescale 1ns/1ps
`default_nettype none
module lnac_rx_filter
  import lnac_pkg::*;
(
  input wire logic [15:0] dest_id_i,
  input wire logic [9:0] bus_identity_i,
  input wire logic [5:0] node_identity_i,
  input wire logic identity_valid_i,
  input wire logic block_low_i,
  input wire logic block_high_i,
  input wire logic region_low_i,
  input wire logic region_high_i,
  output logic accept_o
);
  logic bus_ok;
  logic node_ok;
  logic bcast_ok;
  logic [9:0] dest_bus;
  logic [5:0] dest_node;

  always_comb begin
    dest_bus = dest_id_i[15:6];
    dest_node = dest_id_i[5:0];
    bus_ok = (dest_bus == bus_identity_i) || (dest_bus == LNAC_BUS_LOCAL);
    // Broadcasts into a blocked bus-dependent area are dropped
    bcast_ok = (dest_node == LNAC_NODE_BCAST) &&
               !(block_low_i && region_low_i) && !(block_high_i && region_high_i);
    node_ok = identity_valid_i && (dest_node == node_identity_i);
    accept_o = bus_ok && (node_ok || bcast_ok);
  end
endmodule : lnac_rx_filter
`default_nettype wire

// file: testbench/lnac_phy_model.sv
// Purpose: Link-side stand-in for the phy, transmitter and receiver events
// Assumes: Tasks are called from the bench, each starting at a rising edge
// Notes: Released data shows the inverse of its last value; region flags keep their last value
`timescale 1ns/1ps
`default_nettype none
module lnac_phy_model (
  input wire logic ref_clk_i,
  output logic ack_valid_o,
  output logic [3:0] ack_code_o,
  output logic ack_timeout_o,
  output logic hdr_valid_o,
  output logic [15:0] dest_o,
  output logic region_low_o,
  output logic region_high_o,
  output logic ack_req_o,
  output logic busy_needed_o,
  output logic [1:0] retry_o,
  output logic selfid_valid_o,
  output logic [31:0] q0_o,
  output logic [31:0] q1_o
);
  initial begin
    {ack_valid_o, ack_code_o, ack_timeout_o, hdr_valid_o, dest_o} = '0;
    {region_low_o, region_high_o, ack_req_o, busy_needed_o, retry_o} = '0;
    {selfid_valid_o, q0_o, q1_o} = '0;
  end

  // ==========================================================
  // Event pulses, one cycle each
  task automatic ack(input logic to, input logic [3:0] c);
    @(posedge ref_clk_i);
    ack_valid_o <= !to;
    ack_timeout_o <= to;
    ack_code_o <= c;
    @(posedge ref_clk_i);
    ack_valid_o <= 1'b0;
    ack_timeout_o <= 1'b0;
    ack_code_o <= ~c;
  endtask : ack

  task automatic hdr(input logic [15:0] d, input logic l, input logic h);
    @(posedge ref_clk_i);
    hdr_valid_o <= 1'b1;
    dest_o <= d;
    region_low_o <= l;
    region_high_o <= h;
    @(posedge ref_clk_i);
    hdr_valid_o <= 1'b0;
    dest_o <= ~d;
  endtask : hdr

  task automatic ackreq(input logic need, input logic [1:0] r);
    @(posedge ref_clk_i);
    ack_req_o <= 1'b1;
    busy_needed_o <= need;
    retry_o <= r;
    @(posedge ref_clk_i);
    ack_req_o <= 1'b0;
    busy_needed_o <= !need;
    retry_o <= ~r;
  endtask : ackreq

  task automatic selfid(input logic [31:0] a, input logic [31:0] b);
    @(posedge ref_clk_i);
    selfid_valid_o <= 1'b1;
    q0_o <= a;
    q1_o <= b;
    @(posedge ref_clk_i);
    selfid_valid_o <= 1'b0;
    q0_o <= ~a;
    q1_o <= ~b;
  endtask : selfid
endmodule : lnac_phy_model
`default_nettype wire

// file: testbench/link_node_address_and_control_tb_top.sv
// Purpose: Self-checking bench for the node identity and control bank
// Assumes: Host pins are slow; each access waits for host_done_o
// Notes: Reserved node bits keep their reset ones; field checks mask them
`timescale 1ns/1ps
`default_nettype none
module link_node_address_and_control_tb_top
  import lnac_pkg::*;
;
  typedef struct packed {logic [15:0] dest; logic rl; logic rh; logic acc;} lnac_row_t;
  logic ref_clk, rst_n, cs_n, wr, ovr, txi, txo, idv, done;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rd, q0, q1;
  logic ack_v, ack_to, hv, rl, rh, acc_v, acc, ar, bn, bv, sv, ss;
  logic [3:0] ack_c, bc, st, e;
  logic [1:0] rc;
  logic [15:0] dest, sid;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  lnac_row_t rows [8] = '{'{16'h0485, 1'b0, 1'b0, 1'b1}, '{16'h0486, 1'b0, 1'b0, 1'b0},
    '{16'hffc5, 1'b0, 1'b0, 1'b1}, '{16'h04c5, 1'b0, 1'b0, 1'b0},
    '{16'h04bf, 1'b0, 1'b0, 1'b1}, '{16'h04bf, 1'b1, 1'b0, 1'b0},
    '{16'h04bf, 1'b0, 1'b1, 1'b1}, '{16'hffff, 1'b0, 1'b0, 1'b1}};

  lnac_top u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .host_cs_n_i(cs_n), .host_wr_i(wr),
    .register_address_lines_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_done_o(done), .diag_register_write_override_i(ovr), .at_ack_valid_i(ack_v),
    .at_ack_code_i(ack_c), .at_ack_timeout_i(ack_to), .rx_hdr_valid_i(hv),
    .rx_dest_id_i(dest), .rx_region_low_i(rl), .rx_region_high_i(rh),
    .rx_accept_valid_o(acc_v), .rx_accept_o(acc), .rx_ack_req_i(ar),
    .rx_busy_needed_i(bn), .rx_retry_code_i(rc), .busy_ack_valid_o(bv),
    .busy_ack_code_o(bc), .selfid_valid_i(sv), .selfid_q0_i(q0), .selfid_q1_i(q1),
    .selfid_store_o(ss), .selfid_status_o(st), .tx_arb_request_i(txi),
    .tx_arb_request_o(txo), .source_id_o(sid), .identity_valid_o(idv));
  lnac_phy_model u_phy (.ref_clk_i(ref_clk), .ack_valid_o(ack_v), .ack_code_o(ack_c),
    .ack_timeout_o(ack_to), .hdr_valid_o(hv), .dest_o(dest), .region_low_o(rl),
    .region_high_o(rh), .ack_req_o(ar), .busy_needed_o(bn), .retry_o(rc),
    .selfid_valid_o(sv), .q0_o(q0), .q1_o(q1));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, x, g);
    end
  endtask : chk

  // Address and data settle three cycles before chip select, as the syncs need
  task automatic host(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    wr <= w;
    addr <= a;
    wdata <= d;
    repeat (3) @(posedge ref_clk);
    cs_n <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk("host_done", 32'h0000_0001, {31'h0, done});
    rd = rdata;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : host

  task automatic test_done;
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, wr, ovr, txi, addr, wdata} = '0;
    cs_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("node_rst", 32'hffff_0000, rd);
    host(1'b0, LNAC_OFF_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0000_0000, rd);
    host(1'b1, LNAC_OFF_CTRL, 32'ha5a5_5a5a);
    host(1'b1, 8'h00, 32'h1234_5678);
    host(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0000_0000, rd);
    host(1'b0, LNAC_OFF_CTRL, 32'h0);
    chk("ctrl_rw", 32'ha5a5_5a5a, rd);
    host(1'b1, LNAC_OFF_NODE, 32'hffff_1412);
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("node_wr", 32'h0f00_1412, rd & 32'h0f00_ffff);
    chk("source_id", 32'h0000_0485, {16'h0, sid});
    ovr <= 1'b1;
    host(1'b1, LNAC_OFF_NODE, 32'h0300_1412);
    ovr <= 1'b0;
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("ack_ovr", 32'h0300_1412, rd & 32'h0f00_ffff);
    chk("node_rsvd", 32'hf0ff_0000, rd & 32'hf0ff_0000);
    u_phy.ack(1'b0, 4'h2);
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("ack_cap", 32'h0200_1412, rd & 32'h0f00_ffff);
    u_phy.ack(1'b1, 4'h9);
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("ack_tmo", 32'h0000_1412, rd & 32'h0f00_ffff);
    txi <= 1'b1;
    host(1'b1, LNAC_OFF_CTRL, 32'h0000_1021);
    chk("tx_on", 32'h0000_0001, {31'h0, txo});
    chk("identity_valid", 32'h0000_0001, {31'h0, idv});
    foreach (rows[i]) begin
      u_phy.hdr(rows[i].dest, rows[i].rl, rows[i].rh);
      @(negedge ref_clk);
      chk("accept_valid", 32'h0000_0001, {31'h0, acc_v});
      chk("accept", {31'h0, rows[i].acc}, {31'h0, acc});
    end
    // ==========================================================
    // Hand-written cases
    host(1'b1, LNAC_OFF_CTRL, 32'h0000_0000);
    chk("tx_off", 32'h0000_0000, {31'h0, txo});
    u_phy.hdr(16'h0485, 1'b0, 1'b0);
    @(negedge ref_clk);
    chk("own_noid", 32'h0000_0000, {31'h0, acc});
    u_phy.hdr(16'h04bf, 1'b0, 1'b0);
    @(negedge ref_clk);
    chk("bcast_noid", 32'h0000_0001, {31'h0, acc});
    for (int m = 0; m < 8; m++) begin
      host(1'b1, LNAC_OFF_CTRL, {27'h0, m[2:0], 2'b00});
      for (int b = 0; b < 3; b++) begin
        u_phy.ackreq(b != 0, (b == 2) ? 2'b01 : 2'b00);
        @(negedge ref_clk);
        e = (m[1:0] == 2'b01) ? LNAC_ACK_BUSY_A : LNAC_ACK_BUSY_X;
        e = (m[1:0] == 2'b10) ? LNAC_ACK_BUSY_B : e;
        e = (b == 2) ? LNAC_ACK_BUSY_X : e;
        chk("busy_valid", {31'h0, (b != 0) || m[2]}, {31'h0, bv});
        if (b != 0 || m[2]) chk("busy_code", {28'h0, e}, {28'h0, bc});
      end
    end
    host(1'b1, LNAC_OFF_CTRL, 32'h0000_0002);
    u_phy.selfid(32'h1234_5678, 32'hedcb_a987);
    @(negedge ref_clk);
    chk("sid_store", 32'h0000_0001, {31'h0, ss});
    chk("sid_good", {28'h0, LNAC_SELFID_GOOD}, {28'h0, st});
    u_phy.selfid(32'h1234_5678, 32'h1234_5678);
    @(negedge ref_clk);
    chk("sid_bad", {28'h0, LNAC_SELFID_BAD}, {28'h0, st});
    host(1'b1, LNAC_OFF_CTRL, 32'h0000_0000);
    u_phy.selfid(32'h0000_ffff, 32'hffff_0000);
    @(negedge ref_clk);
    chk("sid_off", 32'h0000_000d, {27'h0, ss, st});
    // Mid-run reset: held state must fall back, then the host bus works again
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("rst_done", 32'h0000_0000, {31'h0, done});
    chk("rst_rdata", 32'h0000_0000, rdata);
    chk("rst_identity_valid", 32'h0000_0000, {31'h0, idv});
    chk("rst_source", {16'h0, LNAC_NODE_RST[9:0], LNAC_NODE_RST[15:10]}, {16'h0, sid});
    chk("rst_sid", {28'h0, LNAC_SELFID_GOOD}, {28'h0, st});
    rst_n <= 1'b1;
    host(1'b0, LNAC_OFF_NODE, 32'h0);
    chk("node_rst2", LNAC_NODE_RST, rd);
    host(1'b0, LNAC_OFF_CTRL, 32'h0);
    chk("ctrl_rst2", LNAC_CTRL_RST, rd);
    test_done();
  end
endmodule : link_node_address_and_control_tb_top
`default_nettype wire
